// ===== rtl/gain_step_defs.vh
`ifndef GAIN_STEP_DEFS_VH
`define GAIN_STEP_DEFS_VH

// ----------------------------------------
// Gain code layout
// ----------------------------------------
`define GAIN_CODE_WIDTH   4
`define GAIN_CODE_MAX     4'hF
`define GAIN_CODE_MIN     4'h0
`define GAIN_CODE_RESET   4'hB
`define GAIN_STEP_DB      3
`define GAIN_TOP_DB       12
`define GAIN_BOTTOM_DB    -33

// ----------------------------------------
// Reset values
// ----------------------------------------
// Pin order: polarity, shutdown, direction, step clock
`define PIN_SYNC_RESET    4'h8
`define STATUS_RESET      1'b0

`endif

// ===== rtl/updown_gain_step_control.v
`timescale 1ns/1ps
`include "gain_step_defs.vh"

module updown_gain_step_control #(
  parameter GAIN_WIDTH = `GAIN_CODE_WIDTH
) (
  input  wire                  core_clk,
  input  wire                  rst,
  input  wire                  step_clock,
  input  wire                  gain_direction,
  input  wire                  power_down_input,
  input  wire                  power_down_polarity,
  output reg  [GAIN_WIDTH-1:0] gain_code,
  output reg                   gain_at_top,
  output reg                   gain_at_bottom,
  output reg                   shutdown,
  output reg                   step_taken
);

  // ----------------------------------------
  // Constants
  // ----------------------------------------
  localparam                  PIN_COUNT  = 4;
  localparam                  PIN_STEP   = 0;
  localparam                  PIN_DIR    = 1;
  localparam                  PIN_PD     = 2;
  localparam                  PIN_POL    = 3;
  localparam [GAIN_WIDTH-1:0] CODE_TOP   = `GAIN_CODE_MAX;
  localparam [GAIN_WIDTH-1:0] CODE_FLOOR = `GAIN_CODE_MIN;
  localparam [GAIN_WIDTH-1:0] CODE_START = `GAIN_CODE_RESET;
  localparam [GAIN_WIDTH-1:0] CODE_UNIT  = {{(GAIN_WIDTH-1){1'b0}}, 1'b1};
  localparam [PIN_COUNT-1:0]  SYNC_START = `PIN_SYNC_RESET;

  // ----------------------------------------
  // Pin bundle
  // ----------------------------------------
  wire [PIN_COUNT-1:0] pin_raw;
  wire [PIN_COUNT-1:0] pin_sync;

  assign pin_raw[PIN_STEP] = step_clock;
  assign pin_raw[PIN_DIR]  = gain_direction;
  assign pin_raw[PIN_PD]   = power_down_input;
  assign pin_raw[PIN_POL]  = power_down_polarity;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Polarity stages start high so shutdown reads inactive until
  // the real pin levels have passed both flip-flops.
  genvar i;

  generate
    for (i = 0; i < PIN_COUNT; i = i + 1) begin : g_sync
      reg first_stage;
      reg second_stage;

      always @(posedge core_clk or posedge rst) begin
        if (rst) begin
          first_stage  <= SYNC_START[i];
          second_stage <= SYNC_START[i];
        end else begin
          first_stage  <= pin_raw[i];
          second_stage <= first_stage;
        end
      end

      assign pin_sync[i] = second_stage;
    end
  endgenerate

  // ----------------------------------------
  // Synchronised pin levels
  // ----------------------------------------
  wire step_level;
  wire direction_up;
  wire pd_level;
  wire pol_level;

  assign step_level   = pin_sync[PIN_STEP];
  assign direction_up = pin_sync[PIN_DIR];
  assign pd_level     = pin_sync[PIN_PD];
  assign pol_level    = pin_sync[PIN_POL];

  // ----------------------------------------
  // Step-clock edge detector
  // ----------------------------------------
  // Reset value matches the idle-low step clock, so no false step
  // follows reset; a clock held high through reset steps once.
  reg  step_level_prev;
  wire step_rise;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      step_level_prev <= 1'b0;
    end else begin
      step_level_prev <= step_level;
    end
  end

  assign step_rise = step_level & ~step_level_prev;

  // ----------------------------------------
  // Step decode
  // ----------------------------------------
  // Direction passes the same two stages as the clock, so it is
  // read at the same sampling instant as the edge it belongs to.
  wire at_top_now;
  wire at_floor_now;
  wire want_up;
  wire want_down;
  wire do_up;
  wire do_down;

  assign at_top_now   = (gain_code == CODE_TOP);
  assign at_floor_now = (gain_code == CODE_FLOOR);
  assign want_up      = step_rise & direction_up;
  assign want_down    = step_rise & ~direction_up;
  assign do_up        = want_up & ~at_top_now;
  assign do_down      = want_down & ~at_floor_now;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  reg [GAIN_WIDTH-1:0] next_gain;
  reg                  next_taken;
  reg                  next_at_top;
  reg                  next_at_bottom;
  reg                  next_shutdown;

  always @* begin
    next_gain  = gain_code;
    next_taken = 1'b0;
    if (do_up) begin
      next_gain  = gain_code + CODE_UNIT;
      next_taken = 1'b1;
    end else if (do_down) begin
      next_gain  = gain_code - CODE_UNIT;
      next_taken = 1'b1;
    end
  end

  // Flags follow the new code, so they never lag the gain output
  always @* begin
    next_at_top    = (next_gain == CODE_TOP);
    next_at_bottom = (next_gain == CODE_FLOOR);
  end

  // Either pin level may mean sleep; agreement is what counts
  always @* begin
    next_shutdown = ~(pd_level ^ pol_level);
  end

  // ----------------------------------------
  // Gain register
  // ----------------------------------------
  // One code for both channels. Shutdown neither blocks nor reloads
  // it, so the setting survives sleep and may still be stepped there.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gain_code <= CODE_START;
    end else begin
      gain_code <= next_gain;
    end
  end

  // ----------------------------------------
  // End-of-range flags
  // ----------------------------------------
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gain_at_top <= `STATUS_RESET;
    end else begin
      gain_at_top <= next_at_top;
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gain_at_bottom <= `STATUS_RESET;
    end else begin
      gain_at_bottom <= next_at_bottom;
    end
  end

  // ----------------------------------------
  // Shutdown status
  // ----------------------------------------
  // Lags the pins by three clocks; a glitch shorter than that may
  // still show for one cycle, as nothing filters it here.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      shutdown <= `STATUS_RESET;
    end else begin
      shutdown <= next_shutdown;
    end
  end

  // ----------------------------------------
  // Step pulse
  // ----------------------------------------
  // High for one cycle only when the code really moved; refused
  // steps at either end leave it low.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      step_taken <= `STATUS_RESET;
    end else begin
      step_taken <= next_taken;
    end
  end

endmodule // updown_gain_step_control

// ===== verif/gain_step_asserts.sv
`timescale 1ns/1ps
module gain_step_asserts (
  input wire       core_clk,
  input wire       rst,
  input wire       power_down_input,
  input wire       power_down_polarity,
  input wire       gain_at_top,
  input wire       gain_at_bottom,
  input wire       shutdown,
  input wire       step_taken,
  input wire       step_clock,
  input wire       gain_direction,
  input wire [3:0] gain_code
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_hold; !step_taken |-> $stable(gain_code); endproperty
  a_hold: assert property(p_hold) else $error("gain moved without step");
  property p_one; step_taken |-> gain_code==$past(gain_code)+4'h1 || gain_code==$past(gain_code)-4'h1; endproperty
  a_one: assert property(p_one) else $error("step not one unit");
  property p_top; gain_at_top==(gain_code==4'hF) && gain_at_bottom==(gain_code==4'h0); endproperty
  a_top: assert property(p_top) else $error("end flag wrong");
  // Pins before a reset release are not yet through the synchronisers
  property p_sd; !$past(rst,3) |-> shutdown==$past(power_down_input==power_down_polarity,3); endproperty
  a_sd: assert property(p_sd) else $error("shutdown wrong");
  property p_rst; $fell(rst) |-> gain_code==4'hB && !step_taken && !shutdown && !gain_at_top && !gain_at_bottom;
  endproperty
  a_rst: assert property(p_rst) else $error("reset state wrong");
  property p_pulse; step_taken |=> !step_taken; endproperty
  a_pulse: assert property(p_pulse) else $error("two steps in a row");
  property p_nowrap; step_taken |-> !($past(gain_code)==4'hF && gain_code==4'h0)
    && !($past(gain_code)==4'h0 && gain_code==4'hF); endproperty
  a_nowrap: assert property(p_nowrap) else $error("gain wrapped");
  c_top: cover property(step_taken && gain_at_top);
  c_bot: cover property(step_taken && gain_at_bottom);
  c_sd: cover property(shutdown && step_taken);
endmodule // gain_step_asserts

// ===== verif/step_host_model.sv
`timescale 1ns/1ps
module step_host_model (
  input  logic core_clk,
  output logic step_clock,
  output logic gain_direction
);
  initial begin
    step_clock = 0;
    gain_direction = 1;
  end
  // Clock rests low between steps; direction settles 400 ns before the edge
  task automatic step(input logic d);
    @(posedge core_clk);
    gain_direction <= d;
    repeat (4) @(posedge core_clk);
    step_clock <= 1;
    repeat (4) @(posedge core_clk);
    step_clock <= 0;
    repeat (3) @(posedge core_clk);
  endtask
endmodule // step_host_model

// ===== verif/updown_gain_step_control_bench.sv
`timescale 1ns/1ps
module updown_gain_step_control_bench;
  logic core_clk=0, rst=1, pd_in=0, pd_pol=1, sclk, dir, top, bot, sd, stp;
  logic [3:0] code;
  int failures=0, n_checks=0, n_steps=0, base=0;
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) if (stp === 1'b1) n_steps <= n_steps + 1;
  step_host_model u_host(.core_clk(core_clk), .step_clock(sclk), .gain_direction(dir));
  updown_gain_step_control u_dut(.core_clk(core_clk), .rst(rst), .step_clock(sclk), .gain_direction(dir),
    .power_down_input(pd_in), .power_down_polarity(pd_pol), .gain_code(code), .gain_at_top(top),
    .gain_at_bottom(bot), .shutdown(sd), .step_taken(stp));
  task chk(string n, logic [3:0] s, e);
    n_checks++;
    if (s !== e) begin failures++; $display("BAD %s exp %h got %h", n, e, s); end
  endtask
  task run(logic d, int k); repeat (k) u_host.step(d); endtask
  task settle; repeat (5) @(posedge core_clk); #1; endtask
  task conclude;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task t_top;
    base = n_steps;
    run(1, 4);
    chk("code", code, 4'hF);
    chk("steps", 4'(n_steps - base), 4'h4);
    chk("top", {3'h0, top}, 4'h1);
    base = n_steps;
    run(1, 1);
    chk("code", code, 4'hF);
    chk("steps", 4'(n_steps - base), 4'h0);
    $display("top done");
  endtask
  task t_bot;
    run(0, 20);
    chk("code", code, 4'h0);
    chk("bot", {3'h0, bot}, 4'h1);
    chk("top", {3'h0, top}, 4'h0);
    base = n_steps;
    run(0, 1);
    chk("steps", 4'(n_steps - base), 4'h0);
    $display("bottom done");
  endtask
  task t_sd;
    @(posedge core_clk) pd_in <= 1;
    settle;
    chk("sd", {3'h0, sd}, 4'h1);
    run(1, 2);
    @(posedge core_clk) pd_in <= 0;
    settle;
    chk("sd", {3'h0, sd}, 4'h0);
    chk("code", code, 4'h2);
    $display("shutdown done");
  endtask
  task t_pol;
    @(posedge core_clk) pd_pol <= 0;
    settle;
    chk("sd", {3'h0, sd}, 4'h1);
    @(posedge core_clk) pd_in <= 1;
    settle;
    chk("sd", {3'h0, sd}, 4'h0);
    @(posedge core_clk) begin pd_in <= 0; pd_pol <= 1; end
    settle;
    chk("code", code, 4'h2);
    $display("polarity done");
  endtask
  task t_rst;
    @(posedge core_clk) rst <= 1;
    repeat (2) @(posedge core_clk);
    rst <= 0;
    @(posedge core_clk); #1;
    chk("code", code, 4'hB);
    chk("sd", {3'h0, sd}, 4'h0);
    run(0, 1);
    chk("code", code, 4'hA);
    $display("reset done");
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 0;
    @(posedge core_clk); #1 chk("code", code, 4'hB);
    chk("stp", {3'h0, stp}, 4'h0);
    t_top; t_bot; t_sd; t_pol; t_rst; conclude;
  end
  initial begin #100000; failures++; conclude; end
endmodule // updown_gain_step_control_bench
bind updown_gain_step_control gain_step_asserts u_chk(.*);
